/* dv/dprp_monitor.sv */
`timescale 1ns/1ps
module dprp_monitor (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ck,
  input wire logic cke,
  input wire logic odt,
  input wire logic [3:0] cmd,
  input wire logic a10,
  input wire logic [1:0] ba
);
  logic ckd_reg, cke_reg, sr_reg, pa_reg, rise, nop;
  logic [3:0] open_reg;
  int hl_reg, rp_reg, rf_reg, xs_reg, bu_reg;
  assign rise = ck && !ckd_reg;
  assign nop = cmd[3] || cmd == dprp_pkg::CMD_NOP;
  // Pin state other than odt and ck is judged only at link rising edges, as the device sees it
  always_ff @(posedge core_clk_in) begin
    ckd_reg <= ck;
    if (!resetn_in) begin
      cke_reg <= 1'b1;
      sr_reg <= 1'b0;
      pa_reg <= 1'b1;
      open_reg <= 4'h0;
      hl_reg <= 3;
      rp_reg <= 99;
      rf_reg <= 99;
      xs_reg <= 999;
      bu_reg <= 99;
    end else if (rise) begin
      cke_reg <= cke;
      hl_reg <= cke != cke_reg ? 1 : hl_reg + 1;
      rp_reg <= cmd == dprp_pkg::CMD_PRE ? 0 : rp_reg + 1;
      pa_reg <= cmd == dprp_pkg::CMD_PRE ? a10 : pa_reg;
      rf_reg <= cmd == dprp_pkg::CMD_REF && cke ? 0 : rf_reg + 1;
      bu_reg <= cmd[3:1] == 3'h2 ? 0 : bu_reg + 1;
      sr_reg <= sr_reg ? !cke : cmd == dprp_pkg::CMD_REF && !cke;
      xs_reg <= sr_reg && cke ? 0 : xs_reg + 1;
      if (cmd == dprp_pkg::CMD_ACT) open_reg[ba] <= 1'b1;
      if (cmd == dprp_pkg::CMD_PRE && a10) open_reg <= 4'h0;
      else if (cmd == dprp_pkg::CMD_PRE || (cmd[3:1] == 3'h2 && a10)) open_reg[ba] <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  property p_odt_off;
    (sr_reg || xs_reg + 1 < dprp_pkg::TXSRD_CK) |-> !odt;
  endproperty
  a_odt_off: assert property (p_odt_off) else $error("odt high near self refresh");
  property p_cke_hold;
    rise && cke != cke_reg |-> hl_reg >= dprp_pkg::TCKE_CK;
  endproperty
  a_cke_hold: assert property (p_cke_hold) else $error("cke level held too short");
  property p_cke_cmd;
    rise && cke != cke_reg |-> nop || (!cke && cmd == dprp_pkg::CMD_REF);
  endproperty
  a_cke_cmd: assert property (p_cke_cmd) else $error("cke change with bad command");
  property p_pre_wait;
    rise && !nop |-> rp_reg + 1 >= (pa_reg ? dprp_pkg::TRPA_CK : dprp_pkg::TRP_CK);
  endproperty
  a_pre_wait: assert property (p_pre_wait) else $error("command inside precharge time");
  property p_ref_wait;
    rise && !nop |-> rf_reg + 1 >= dprp_pkg::TRFC_CK;
  endproperty
  a_ref_wait: assert property (p_ref_wait) else $error("command inside refresh time");
  property p_ref_idle;
    rise && cmd == dprp_pkg::CMD_REF |-> open_reg == 4'h0;
  endproperty
  a_ref_idle: assert property (p_ref_idle) else $error("refresh with open bank");
  property p_xs_nop;
    rise && xs_reg + 1 < dprp_pkg::TXSNR_CK |-> nop;
  endproperty
  a_xs_nop: assert property (p_xs_nop) else $error("command soon after self refresh exit");
  property p_xs_read;
    rise && cmd == dprp_pkg::CMD_READ |-> xs_reg + 1 >= dprp_pkg::TXSRD_CK;
  endproperty
  a_xs_read: assert property (p_xs_read) else $error("read too soon after exit");
  property p_burst_cke;
    rise && cke_reg && !cke |-> bu_reg + 1 >= dprp_pkg::TBURST_CK && xs_reg + 1 >= dprp_pkg::TXSNR_CK;
  endproperty
  a_burst_cke: assert property (p_burst_cke) else $error("cke low during burst or exit");
  property p_ck_steady;
    $changed(ck) |=> $stable(ck) [*5] ##1 $changed(ck);
  endproperty
  a_ck_steady: assert property (p_ck_steady) else $error("link clock not steady");
endmodule : dprp_monitor

/* dv/dprp_tb.sv */
`timescale 1ns/1ps
module dprp_tb;
  logic core_clk_in, resetn_in, hot_in, user_a10_in, user_valid_in, sref_req_in, pd_req_in, cke_w;
  logic [3:0] user_cmd_in;
  logic [1:0] user_ba_in;
  logic user_ready_out, busy_out, refresh_busy_out, self_refresh_out, pd_precharge_out, pd_active_out;
  logic buffers_on_out, dll_frozen_out, nonread_ok_out, read_ok_out, protocol_err_out;
  logic [3:0] bank_open_out;
  logic [9:0] notes[$];
  int fails;
  int n_tests;
  event chk;
  dprp_link_if link ();
  dprp_ctrl i_dprp_ctrl (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .hot_in(hot_in),
    .user_cmd_in(user_cmd_in), .user_a10_in(user_a10_in), .user_ba_in(user_ba_in), .user_valid_in(user_valid_in),
    .sref_req_in(sref_req_in), .pd_req_in(pd_req_in), .user_ready_out(user_ready_out), .busy_out(busy_out),
    .link(link));
  dprp_device i_dprp_device (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .link(link),
    .bank_open_out(bank_open_out), .refresh_busy_out(refresh_busy_out), .self_refresh_out(self_refresh_out),
    .pd_precharge_out(pd_precharge_out), .pd_active_out(pd_active_out), .buffers_on_out(buffers_on_out),
    .dll_frozen_out(dll_frozen_out), .nonread_ok_out(nonread_ok_out), .read_ok_out(read_ok_out),
    .protocol_err_out(protocol_err_out));
  dprp_monitor i_dprp_monitor (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .ck(link.ck), .cke(link.cke),
    .odt(link.odt), .cmd(link.cmd), .a10(link.a10), .ba(link.ba));
  always_comb cke_w = link.cke;
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  task automatic results();
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic cmp_banks(input logic [3:0] e, input logic [3:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch banks t=%0t exp=%0h got=%0h", $time, e, g);
    end
  endtask : cmp_banks
  task automatic cmp_state(input logic [5:0] e, input logic [5:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch state t=%0t exp=%0h got=%0h", $time, e, g);
    end
  endtask : cmp_state
  task automatic cmp_lat(input int lo, input int hi, input int g);
    n_tests++;
    if (g < lo || g > hi) begin
      fails++;
      $display("mismatch cycles t=%0t exp=%0h..%0h got=%0h", $time, lo, hi, g);
    end
  endtask : cmp_lat
  // Bounded wait; a hang ends the run
  task automatic count_until(ref logic s, input logic v, output int n);
    for (n = 0; n < 6000 && s !== v; n++) @(negedge core_clk_in);
    if (n == 6000) begin
      fails++;
      results();
    end
  endtask : count_until
  task automatic note(input logic [9:0] e);
    repeat (2) @(negedge core_clk_in);
    notes.push_back(e);
    ->chk;
  endtask : note
  // Bank-dependent steps start just after a refresh, so no precharge-all lands inside them
  task automatic after_refresh();
    int n;
    count_until(refresh_busy_out, 1'b1, n);
    count_until(refresh_busy_out, 1'b0, n);
  endtask : after_refresh
  task automatic issue(input logic [3:0] c, input logic a, input logic [1:0] b);
    int n;
    user_cmd_in = c;
    user_a10_in = a;
    user_ba_in = b;
    user_valid_in = 1'b1;
    count_until(user_ready_out, 1'b1, n);
    @(negedge core_clk_in);
    user_valid_in = 1'b0;
    count_until(busy_out, 1'b0, n);
    // Link edge plus sync and status latency
    repeat (24) @(negedge core_clk_in);
  endtask : issue
  always @(chk) begin : watch
    logic [9:0] e;
    e = notes.pop_front();
    cmp_banks(e[9:6], bank_open_out);
    cmp_state(e[5:0], {self_refresh_out, pd_precharge_out, pd_active_out, buffers_on_out, dll_frozen_out,
      protocol_err_out});
  end
  initial begin
    int n, d, b;
    {hot_in, user_a10_in, user_valid_in, sref_req_in, pd_req_in, resetn_in} = 6'h00;
    user_cmd_in = dprp_pkg::CMD_NOP;
    user_ba_in = 2'h0;
    fails = 0;
    n_tests = 0;
    n = $urandom(65442);
    repeat (20) @(negedge core_clk_in);
    resetn_in = 1'b1;
    note({4'h0, 6'h04});
    for (b = 0; b < 4; b++) begin
      issue(dprp_pkg::CMD_ACT, 1'($urandom), 2'(b));
      note({4'((1 << (b + 1)) - 1), 6'h04});
    end
    b = $urandom_range(3);
    issue(dprp_pkg::CMD_PRE, 1'b0, 2'(b));
    note({4'hF & ~(4'h1 << b), 6'h04});
    issue(dprp_pkg::CMD_PRE, 1'b1, 2'($urandom));
    note({4'h0, 6'h04});
    after_refresh();
    issue(dprp_pkg::CMD_ACT, 1'b0, 2'h2);
    issue(dprp_pkg::CMD_WRITE, 1'b1, 2'h2);
    note({4'h0, 6'h04});
    after_refresh();
    issue(dprp_pkg::CMD_ACT, 1'b0, 2'h3);
    issue(dprp_pkg::CMD_READ, 1'b0, 2'h3);
    pd_req_in = 1'b1;
    count_until(pd_active_out, 1'b1, n);
    note({4'h8, 6'h08});
    pd_req_in = 1'b0;
    count_until(pd_active_out, 1'b0, n);
    note({4'h8, 6'h04});
    issue(dprp_pkg::CMD_PRE, 1'b1, 2'h0);
    pd_req_in = 1'b1;
    count_until(pd_precharge_out, 1'b1, n);
    note({4'h0, 6'h12});
    pd_req_in = 1'b0;
    count_until(pd_precharge_out, 1'b0, n);
    sref_req_in = 1'b1;
    count_until(self_refresh_out, 1'b1, n);
    note({4'h0, 6'h20});
    sref_req_in = 1'b0;
    count_until(cke_w, 1'b1, n);
    count_until(nonread_ok_out, 1'b1, n);
    count_until(read_ok_out, 1'b1, d);
    cmp_lat((dprp_pkg::TXSNR_CK - 1) * 12, (dprp_pkg::TXSNR_CK + 2) * 12, n);
    cmp_lat((dprp_pkg::TXSRD_CK - 1) * 12, (dprp_pkg::TXSRD_CK + 2) * 12, n + d);
    count_until(refresh_busy_out, 1'b1, n);
    // First gap starts at a refresh held over from self refresh, so it is not timed
    for (b = 0; b < 4; b++) begin
      hot_in = b > 1;
      count_until(refresh_busy_out, 1'b0, d);
      count_until(refresh_busy_out, 1'b1, n);
      if (b == 0) cmp_lat((dprp_pkg::TRFC_CK - 1) * 12, (dprp_pkg::TRFC_CK + 1) * 12, d);
      if (b == 1) cmp_lat(dprp_pkg::TREFI_CYC - 36, dprp_pkg::TREFI_CYC + 36, n + d);
      if (b == 3) cmp_lat(dprp_pkg::TREFI_HOT_CYC - 36, dprp_pkg::TREFI_HOT_CYC + 36, n + d);
    end
    issue(dprp_pkg::CMD_READ, 1'b0, 2'h1);
    note({4'h0, 6'h05});
    repeat (2) @(negedge core_clk_in);
    results();
  end
endmodule : dprp_tb

/* hdl/dprp_ctrl.sv */
`timescale 1ns/1ps
module dprp_ctrl (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic hot_in,
  input wire logic [3:0] user_cmd_in,
  input wire logic user_a10_in,
  input wire logic [1:0] user_ba_in,
  input wire logic user_valid_in,
  input wire logic sref_req_in,
  input wire logic pd_req_in,
  output logic user_ready_out,
  output logic busy_out,
  dprp_link_if.ctl link
);
  typedef enum logic [6:0] {
    DPRC_IDLE = 7'h01,
    DPRC_WAIT = 7'h02,
    DPRC_PRE_ALL = 7'h04,
    DPRC_REF = 7'h08,
    DPRC_LOW = 7'h10,
    DPRC_EXIT = 7'h20,
    DPRC_SREF = 7'h40
  } dprc_state_e;

  dprc_state_e state_reg;
  logic [3:0] div_reg;
  logic ck_reg, rise_w;
  logic [dprp_pkg::CNT_W-1:0] wait_reg, refi_reg;
  logic [3:0] open_reg;
  logic ref_due_reg, sref_mode_reg;
  logic hot_s;

  // Temperature flag comes from a sensor outside this clock
  dprp_sync #(.W(1)) u_hot_sync (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .d_in(hot_in),
    .q_out(hot_s)
  );

  // Link clock divided from the core clock; commands change on falling half
  assign rise_w = (div_reg == 4'(dprp_pkg::CK_HALF - 1)) && ck_reg;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      div_reg <= 4'h0;
      ck_reg <= 1'b0;
    end else if (div_reg == 4'(dprp_pkg::CK_HALF - 1)) begin
      div_reg <= 4'h0;
      ck_reg <= !ck_reg;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign link.ck = ck_reg;

  // Refresh interval timer
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      refi_reg <= '0;
      ref_due_reg <= 1'b0;
    end else begin
      if (refi_reg == '0) begin
        // Reload one short: the zero cycle counts, so the period is the full interval
        refi_reg <= hot_s ? dprp_pkg::CNT_W'(dprp_pkg::TREFI_HOT_CYC - 1) :
                            dprp_pkg::CNT_W'(dprp_pkg::TREFI_CYC - 1);
        ref_due_reg <= 1'b1;
      end else begin
        refi_reg <= refi_reg - 1'b1;
        if (state_reg == DPRC_REF && rise_w) begin
          ref_due_reg <= 1'b0;
        end
      end
    end
  end

  assign user_ready_out = (state_reg == DPRC_IDLE) && rise_w && !ref_due_reg && !sref_req_in && !pd_req_in;
  assign busy_out = (state_reg != DPRC_IDLE);

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state_reg <= DPRC_IDLE;
      wait_reg <= '0;
      open_reg <= 4'h0;
      sref_mode_reg <= 1'b0;
      link.cke <= 1'b1;
      link.odt <= 1'b0;
      link.cmd <= dprp_pkg::CMD_NOP;
      link.a10 <= 1'b0;
      link.ba <= 2'h0;
    end else if (rise_w) begin
      link.cmd <= dprp_pkg::CMD_NOP;
      link.a10 <= 1'b0;
      case (state_reg)
        DPRC_IDLE: begin
          if (ref_due_reg || sref_req_in) begin
            sref_mode_reg <= !ref_due_reg;
            if (open_reg != 4'h0) begin
              link.cmd <= dprp_pkg::CMD_PRE;
              link.a10 <= 1'b1;
              open_reg <= 4'h0;
              wait_reg <= dprp_pkg::CNT_W'(dprp_pkg::TRPA_CK);
              state_reg <= DPRC_PRE_ALL;
            end else begin
              state_reg <= DPRC_REF;
            end
          end else if (pd_req_in) begin
            link.cke <= 1'b0;
            wait_reg <= dprp_pkg::CNT_W'(dprp_pkg::TCKE_CK);
            state_reg <= DPRC_LOW;
          end else if (user_valid_in) begin
            link.cmd <= user_cmd_in;
            link.a10 <= user_a10_in;
            link.ba <= user_ba_in;
            wait_reg <= dprp_pkg::CNT_W'(1);
            if (user_cmd_in == dprp_pkg::CMD_ACT) begin
              open_reg[user_ba_in] <= 1'b1;
            end else if (user_cmd_in == dprp_pkg::CMD_PRE) begin
              wait_reg <= user_a10_in ? dprp_pkg::CNT_W'(dprp_pkg::TRPA_CK) :
                                        dprp_pkg::CNT_W'(dprp_pkg::TRP_CK);
              if (user_a10_in) open_reg <= 4'h0;
              else open_reg[user_ba_in] <= 1'b0;
            end else if (user_cmd_in == dprp_pkg::CMD_READ || user_cmd_in == dprp_pkg::CMD_WRITE) begin
              wait_reg <= dprp_pkg::CNT_W'(dprp_pkg::TBURST_CK);
              if (user_a10_in) open_reg[user_ba_in] <= 1'b0;
            end
            state_reg <= DPRC_WAIT;
          end
        end
        DPRC_WAIT, DPRC_PRE_ALL: begin
          if (wait_reg <= dprp_pkg::CNT_W'(1)) begin
            state_reg <= (state_reg == DPRC_PRE_ALL) ? DPRC_REF : DPRC_IDLE;
          end else begin
            wait_reg <= wait_reg - 1'b1;
          end
        end
        DPRC_REF: begin
          link.cmd <= dprp_pkg::CMD_REF;
          if (sref_mode_reg) begin
            link.cke <= 1'b0;
            wait_reg <= dprp_pkg::CNT_W'(dprp_pkg::TCKE_CK);
            state_reg <= DPRC_SREF;
          end else begin
            wait_reg <= dprp_pkg::CNT_W'(dprp_pkg::TRFC_CK);
            state_reg <= DPRC_WAIT;
          end
        end
        DPRC_SREF, DPRC_LOW: begin
          // Held low at least tCKE, then until the request drops
          if (wait_reg > dprp_pkg::CNT_W'(1)) begin
            wait_reg <= wait_reg - 1'b1;
          end else if (state_reg == DPRC_SREF ? !sref_req_in : !pd_req_in) begin
            link.cke <= 1'b1;
            wait_reg <= (state_reg == DPRC_SREF) ? dprp_pkg::CNT_W'(dprp_pkg::TXSRD_CK) :
                                                   dprp_pkg::CNT_W'(dprp_pkg::TXP_CK);
            state_reg <= DPRC_EXIT;
          end
        end
        DPRC_EXIT: begin
          // NOP only; CKE stays high for the whole wait
          if (wait_reg <= dprp_pkg::CNT_W'(1)) begin
            state_reg <= DPRC_IDLE;
          end else begin
            wait_reg <= wait_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= DPRC_IDLE;
        end
      endcase
    end
  end
endmodule : dprp_ctrl

/* hdl/dprp_device.sv */
`timescale 1ns/1ps
module dprp_device (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  dprp_link_if.dev link,
  output logic [3:0] bank_open_out,
  output logic refresh_busy_out,
  output logic self_refresh_out,
  output logic pd_precharge_out,
  output logic pd_active_out,
  output logic buffers_on_out,
  output logic dll_frozen_out,
  output logic nonread_ok_out,
  output logic read_ok_out,
  output logic protocol_err_out
);
  typedef enum logic [4:0] {
    DPRP_NORMAL = 5'h01,
    DPRP_SREF = 5'h02,
    DPRP_SREF_EXIT = 5'h04,
    DPRP_PD_PRE = 5'h08,
    DPRP_PD_ACT = 5'h10
  } dprp_state_e;

  // All link pins are sampled into the core domain before use
  logic [9:0] pins_sync;
  dprp_sync #(.W(10)) u_sync (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .d_in({link.ck, link.cke, link.odt, link.cmd, link.a10, link.ba}),
    .q_out(pins_sync)
  );
  logic ck_s, cke_s, odt_s, a10_s;
  logic [3:0] cmd_s;
  logic [1:0] ba_s;
  assign {ck_s, cke_s, odt_s, cmd_s, a10_s, ba_s} = pins_sync;

  logic ck_prev_reg, cke_prev_reg;
  logic edge_w;
  assign edge_w = ck_s && !ck_prev_reg;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ck_prev_reg <= 1'b0;
    end else begin
      ck_prev_reg <= ck_s;
    end
  end

  logic is_nop_w;
  assign is_nop_w = (cmd_s == dprp_pkg::CMD_NOP) || cmd_s[3];

  dprp_state_e state_reg;
  logic [dprp_pkg::CNT_W-1:0] rfc_cnt_reg, xs_cnt_reg, cke_run_reg, burst_cnt_reg;
  logic [3:0] bank_reg;

  // CKE run length in registered edges
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      cke_prev_reg <= 1'b1;
      cke_run_reg <= '0;
    end else if (edge_w) begin
      cke_prev_reg <= cke_s;
      if (cke_s != cke_prev_reg) begin
        cke_run_reg <= dprp_pkg::CNT_W'(1);
      end else if (cke_run_reg != '1) begin
        cke_run_reg <= cke_run_reg + 1'b1;
      end
    end
  end

  // Bank open tracking
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      bank_reg <= 4'h0;
    end else if (edge_w && cke_s && state_reg == DPRP_NORMAL) begin
      if (cmd_s == dprp_pkg::CMD_ACT) begin
        bank_reg[ba_s] <= 1'b1;
      end else if (cmd_s == dprp_pkg::CMD_PRE) begin
        if (a10_s) begin
          bank_reg <= 4'h0;
        end else begin
          bank_reg[ba_s] <= 1'b0;
        end
      end else if ((cmd_s == dprp_pkg::CMD_READ || cmd_s == dprp_pkg::CMD_WRITE) && a10_s) begin
        bank_reg[ba_s] <= 1'b0;
      end
    end
  end

  // Burst-in-progress window, used to flag early CKE drops
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      burst_cnt_reg <= '0;
    end else if (edge_w) begin
      if (cke_s && (cmd_s == dprp_pkg::CMD_READ || cmd_s == dprp_pkg::CMD_WRITE)) begin
        burst_cnt_reg <= dprp_pkg::CNT_W'(dprp_pkg::TBURST_CK);
      end else if (burst_cnt_reg != '0) begin
        burst_cnt_reg <= burst_cnt_reg - 1'b1;
      end
    end
  end

  // Refresh busy window
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      rfc_cnt_reg <= '0;
    end else if (edge_w) begin
      if (state_reg == DPRP_NORMAL && cmd_s == dprp_pkg::CMD_REF && cke_s) begin
        rfc_cnt_reg <= dprp_pkg::CNT_W'(dprp_pkg::TRFC_CK);
      end else if (rfc_cnt_reg != '0) begin
        rfc_cnt_reg <= rfc_cnt_reg - 1'b1;
      end
    end
  end

  // Power state machine
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state_reg <= DPRP_NORMAL;
      xs_cnt_reg <= '0;
    end else if (edge_w) begin
      case (state_reg)
        DPRP_NORMAL: begin
          if (cke_prev_reg && !cke_s) begin
            if (cmd_s == dprp_pkg::CMD_REF) begin
              state_reg <= DPRP_SREF;
            end else if (is_nop_w) begin
              state_reg <= (bank_reg == 4'h0) ? DPRP_PD_PRE : DPRP_PD_ACT;
            end
          end
        end
        DPRP_SREF: begin
          // Exit seen as soon as CKE rises, without waiting for a command
          if (cke_s) begin
            state_reg <= DPRP_SREF_EXIT;
            xs_cnt_reg <= dprp_pkg::CNT_W'(1);
          end
        end
        DPRP_SREF_EXIT: begin
          if (xs_cnt_reg != '1) begin
            xs_cnt_reg <= xs_cnt_reg + 1'b1;
          end
          if (!cke_s && cmd_s == dprp_pkg::CMD_REF) begin
            state_reg <= DPRP_SREF;
          end else if (xs_cnt_reg >= dprp_pkg::CNT_W'(dprp_pkg::TXSRD_CK)) begin
            state_reg <= DPRP_NORMAL;
          end
        end
        DPRP_PD_PRE, DPRP_PD_ACT: begin
          if (cke_s && is_nop_w) begin
            state_reg <= DPRP_NORMAL;
          end
        end
        default: begin
          state_reg <= DPRP_NORMAL;
        end
      endcase
    end
  end

  // Misuse flag: sticky until reset
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      protocol_err_out <= 1'b0;
    end else if (edge_w) begin
      if (cke_prev_reg != cke_s && cke_run_reg < dprp_pkg::CNT_W'(dprp_pkg::TCKE_CK)) begin
        protocol_err_out <= 1'b1;
      end
      if (!cke_s && burst_cnt_reg != '0) begin
        protocol_err_out <= 1'b1;
      end
      if (state_reg == DPRP_SREF_EXIT && xs_cnt_reg < dprp_pkg::CNT_W'(dprp_pkg::TXSNR_CK) && !is_nop_w) begin
        protocol_err_out <= 1'b1;
      end
      if (state_reg == DPRP_SREF_EXIT && odt_s) begin
        protocol_err_out <= 1'b1;
      end
      if (cke_s && state_reg == DPRP_NORMAL && !bank_reg[ba_s]
          && (cmd_s == dprp_pkg::CMD_READ || cmd_s == dprp_pkg::CMD_WRITE)) begin
        protocol_err_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      bank_open_out <= 4'h0;
      refresh_busy_out <= 1'b0;
      self_refresh_out <= 1'b0;
      pd_precharge_out <= 1'b0;
      pd_active_out <= 1'b0;
      buffers_on_out <= 1'b1;
      dll_frozen_out <= 1'b0;
      nonread_ok_out <= 1'b1;
      read_ok_out <= 1'b1;
    end else begin
      bank_open_out <= bank_reg;
      refresh_busy_out <= (rfc_cnt_reg != '0);
      self_refresh_out <= (state_reg == DPRP_SREF);
      pd_precharge_out <= (state_reg == DPRP_PD_PRE);
      pd_active_out <= (state_reg == DPRP_PD_ACT);
      buffers_on_out <= (state_reg == DPRP_NORMAL) || (state_reg == DPRP_SREF_EXIT);
      dll_frozen_out <= (state_reg == DPRP_PD_PRE);
      nonread_ok_out <= (state_reg == DPRP_NORMAL) ||
        (state_reg == DPRP_SREF_EXIT && xs_cnt_reg >= dprp_pkg::CNT_W'(dprp_pkg::TXSNR_CK));
      read_ok_out <= (state_reg == DPRP_NORMAL);
    end
  end
endmodule : dprp_device

/* hdl/dprp_link_if.sv */
`timescale 1ns/1ps
interface dprp_link_if;
  logic ck;
  logic cke;
  logic odt;
  logic [3:0] cmd;
  logic a10;
  logic [1:0] ba;
  modport dev (input ck, input cke, input odt, input cmd, input a10, input ba);
  modport ctl (output ck, output cke, output odt, output cmd, output a10, output ba);
endinterface : dprp_link_if

/* hdl/dprp_pkg.sv */
package dprp_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BA_W = 2;
  localparam int CLK_PERIOD_PS = 10000;
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_DESEL = 4'h8;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_LMR = 4'h0;
  // Timing figures in link clock cycles
  localparam int TRP_CK = 3;
  localparam int TRPA_CK = 4;
  localparam int TRFC_CK = 26;
  localparam int TXSNR_CK = 28;
  localparam int TXSRD_CK = 200;
  localparam int TCKE_CK = 3;
  localparam int TXP_CK = 2;
  localparam int TBURST_CK = 6;
  // Refresh intervals in ps and in core cycles, rounded down so never late
  localparam int TREFI_PS = 7812500;
  localparam int TREFI_HOT_PS = 3900000;
  localparam int TREFI_CYC = TREFI_PS / CLK_PERIOD_PS;
  localparam int TREFI_HOT_CYC = TREFI_HOT_PS / CLK_PERIOD_PS;
  // Link clock divider: half period in core cycles
  localparam int CK_HALF = 6;
  localparam int CNT_W = 10;
endpackage : dprp_pkg

/* hdl/dprp_sync.sv */
`timescale 1ns/1ps
module dprp_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_reg;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      s1_reg <= '0;
      q_out <= '0;
    end else begin
      s1_reg <= d_in;
      q_out <= s1_reg;
    end
  end
endmodule : dprp_sync
